// file: rtl/power_on_low_voltage_reset.sv
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`include "por_lvd_consts.svh"
module power_on_low_voltage_reset #(
  parameter int RELEASE_CYCLES = `RELEASE_CYCLES,
  parameter int FILTER_CYCLES = `FILTER_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire por_lvd_pkg::addr_t i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire por_lvd_pkg::word_t i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic o_avs_waitrequest,
  output por_lvd_pkg::word_t o_avs_readdata,
  input wire logic i_external_reset_pin_n,
  input wire logic i_power_on_below,
  input wire logic i_reset_threshold_below,
  input wire logic i_drop_threshold_below,
  input wire logic i_rise_threshold_above,
  input wire logic i_external_drop_level_input,
  input wire logic i_external_rise_level_input,
  output logic o_internal_reset,
  output logic o_low_voltage_reset_n,
  output logic o_voltage_level_n,
  output logic o_voltage_interrupt_line,
  output logic o_reset_threshold_select,
  output logic o_external_input_select
);
  import por_lvd_pkg::*;

  localparam int PW = $clog2(RELEASE_CYCLES);
  localparam int FW = $clog2(FILTER_CYCLES + 1);
  localparam logic [PW-1:0] PRESC_LAST = PW'(RELEASE_CYCLES - 1);
  localparam logic [FW-1:0] FILT_LAST = FW'(FILTER_CYCLES - 1);
  localparam logic [1:0] DIV_LAST = 2'(`STAB_DIV - 1);
  localparam int NSYNC = 7;

  generate
    if (RELEASE_CYCLES < 2) begin : g_chk_release
      $error("RELEASE_CYCLES must be at least 2");
    end
    if (FILTER_CYCLES < 1) begin : g_chk_filter
      $error("FILTER_CYCLES must be at least 1");
    end
  endgenerate

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic pin_filt_ff;
  logic [FW-1:0] filt_cnt_ff;
  logic por_hold;
  logic lvd_active;
  logic [PW-1:0] presc_ff;
  logic internal_reset_ff;
  logic lvr_n_ff;
  reg8_t ctl_ff;
  logic ovf_ff;
  logic drop_ff;
  logic rise_ff;
  logic ext_sel_ff;
  logic [2:0] rsvd_ff;
  logic [1:0] div_ff;
  reg8_t stab_cnt_ff;
  logic ovf_set;
  logic drop_lvl;
  logic rise_lvl;
  logic drop_prev_ff;
  logic rise_prev_ff;
  logic dropped_ff;
  logic drop_evt;
  logic rise_evt;
  logic level_n_ff;
  logic irq_ff;
  logic wait_ff;
  word_t rdata_ff;
  logic [2:0] arm_ff;
  logic [2:0] clr;
  logic req;
  logic acc_rd;
  logic acc_wr;
  logic wr_lane0;
  reg_sel_e sel;
  reg8_t rd_mux;

  // Two-stage synchronizers on every asynchronous input
  assign raw_in = {i_external_rise_level_input, i_external_drop_level_input, i_rise_threshold_above,
                   i_drop_threshold_below, i_reset_threshold_below, i_power_on_below, i_external_reset_pin_n};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= raw_in[gi]; // [R22]
          sync2_ff[gi] <= sync1_ff[gi]; // [R22]
        end
      end
    end
  endgenerate

  // Pin level accepted only after it stays stable for the filter time
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_filt_ff <= 1'b0;
      filt_cnt_ff <= '0;
    end else if (sync2_ff[0] == pin_filt_ff) begin
      filt_cnt_ff <= '0;
    end else if (filt_cnt_ff == FILT_LAST) begin
      pin_filt_ff <= sync2_ff[0]; // [R3]
      filt_cnt_ff <= '0;
    end else begin
      filt_cnt_ff <= filt_cnt_ff + FW'(1); // [R3]
    end
  end

  assign por_hold = ~pin_filt_ff | sync2_ff[1]; // [R1] [R10]
  assign lvd_active = ctl_ff[`CTL_DETECT_EN] & sync2_ff[2] &
                      (ctl_ff[`CTL_LVR_EN] | ctl_ff[`CTL_DROP_IE] | ctl_ff[`CTL_RISE_IE]); // [R7] [R16]

  // Reset-release prescaler
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      presc_ff <= '0;
      internal_reset_ff <= 1'b1;
    end else if (por_hold || lvd_active) begin
      presc_ff <= '0; // [R1] [R7]
      internal_reset_ff <= 1'b1; // [R1]
    end else if (internal_reset_ff) begin
      if (presc_ff == PRESC_LAST) begin
        internal_reset_ff <= 1'b0; // [R2] [R8]
      end else begin
        presc_ff <= presc_ff + PW'(1); // [R2] [R8]
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      lvr_n_ff <= 1'b1;
    end else begin
      lvr_n_ff <= ~lvd_active; // [R7]
    end
  end

  // Avalon slave: one wait cycle, then the access completes
  assign req = i_avs_read | i_avs_write;
  assign acc_rd = i_avs_read & ~wait_ff;
  assign acc_wr = i_avs_write & ~wait_ff;
  assign wr_lane0 = acc_wr & i_avs_byteenable[0];
  assign sel = decode_reg(i_avs_address);

  always_comb begin
    rd_mux = 8'h00;
    unique case (sel)
      SEL_CONTROL: rd_mux = ctl_ff;
      SEL_STATUS: rd_mux = {ovf_ff, rsvd_ff, ext_sel_ff, 1'b0, drop_ff, rise_ff};
      SEL_COUNTER: rd_mux = stab_cnt_ff;
      SEL_NONE: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= ~(req & wait_ff);
      if (i_avs_read && wait_ff) begin
        rdata_ff <= {24'h00_0000, rd_mux};
      end
    end
  end

  // Control register: cleared by power-on reset only
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl_ff <= `CTL_RESET;
    end else if (por_hold) begin
      ctl_ff <= `CTL_RESET; // [R4] [R10]
    end else if (wr_lane0 && sel == SEL_CONTROL) begin
      ctl_ff <= i_avs_writedata[7:0] & `CTL_WMASK; // [R9]
    end
  end

  // Stabilization counter on clock divided by four
  assign ovf_set = (div_ff == DIV_LAST) && (stab_cnt_ff == `CNT_LAST);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      div_ff <= 2'h0;
      stab_cnt_ff <= `CNT_RESET;
    end else if (!ctl_ff[`CTL_DETECT_EN] || por_hold) begin
      div_ff <= 2'h0;
      stab_cnt_ff <= `CNT_RESET;
    end else begin
      div_ff <= div_ff + 2'h1; // [R20]
      if (div_ff == DIV_LAST) begin
        stab_cnt_ff <= stab_cnt_ff + 8'h01; // [R20]
      end
    end
  end

  // Level selection and crossing detection
  assign drop_lvl = ext_sel_ff ? ~sync2_ff[5] : sync2_ff[3]; // [R17]
  assign rise_lvl = ext_sel_ff ? sync2_ff[6] : sync2_ff[4]; // [R18]
  assign drop_evt = ctl_ff[`CTL_DETECT_EN] & drop_lvl & ~drop_prev_ff; // [R13] [R23]
  assign rise_evt = ctl_ff[`CTL_DETECT_EN] & rise_lvl & ~rise_prev_ff & dropped_ff & ~sync2_ff[2]; // [R15] [R23]

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      drop_prev_ff <= 1'b0;
      rise_prev_ff <= 1'b0;
      dropped_ff <= 1'b0;
      level_n_ff <= 1'b1;
    end else begin
      drop_prev_ff <= drop_lvl;
      rise_prev_ff <= rise_lvl;
      if (!ctl_ff[`CTL_DETECT_EN] || sync2_ff[2] || por_hold) begin
        dropped_ff <= 1'b0; // [R15]
      end else if (drop_evt) begin
        dropped_ff <= 1'b1; // [R18]
      end else if (rise_evt) begin
        dropped_ff <= 1'b0;
      end
      if (por_hold) begin
        level_n_ff <= 1'b1;
      end else if (drop_evt) begin
        level_n_ff <= 1'b0; // [R13]
      end else if (rise_evt) begin
        level_n_ff <= 1'b1; // [R15]
      end
    end
  end

  // Flags: arm on reading 1, clear on writing 0 while armed; a set wins
  assign clr = (wr_lane0 && sel == SEL_STATUS) ?
               (arm_ff & ~{i_avs_writedata[`STS_OVF], i_avs_writedata[`STS_DROP], i_avs_writedata[`STS_RISE]}) :
               3'h0;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      arm_ff <= 3'h0;
    end else if (por_hold || lvd_active) begin
      arm_ff <= 3'h0;
    end else if (wr_lane0 && sel == SEL_STATUS) begin
      arm_ff <= 3'h0; // [R21]
    end else if (acc_rd && sel == SEL_STATUS) begin
      arm_ff <= arm_ff | {rdata_ff[`STS_OVF], rdata_ff[`STS_DROP], rdata_ff[`STS_RISE]}; // [R21]
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ovf_ff <= 1'b0;
      drop_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else if (por_hold || lvd_active) begin
      ovf_ff <= 1'b0;
      drop_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      ovf_ff <= ovf_set | (ovf_ff & ~clr[2]); // [R20] [R21]
      drop_ff <= drop_evt | (drop_ff & ~clr[1]); // [R13] [R21]
      rise_ff <= (rise_evt & ctl_ff[`CTL_RISE_IE]) | (rise_ff & ~clr[0]); // [R15] [R21]
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_sel_ff <= 1'b0;
      rsvd_ff <= `STS_RSVD_RESET;
    end else if (por_hold) begin
      ext_sel_ff <= 1'b0;
      rsvd_ff <= `STS_RSVD_RESET;
    end else if (wr_lane0 && sel == SEL_STATUS) begin
      ext_sel_ff <= i_avs_writedata[`STS_EXT_SEL];
      rsvd_ff <= i_avs_writedata[6:4];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (drop_ff & ctl_ff[`CTL_DROP_IE]) | (rise_ff & ctl_ff[`CTL_RISE_IE]); // [R13] [R15]
    end
  end

  assign o_avs_waitrequest = wait_ff;
  assign o_avs_readdata = rdata_ff;
  assign o_internal_reset = internal_reset_ff;
  assign o_low_voltage_reset_n = lvr_n_ff;
  assign o_voltage_level_n = level_n_ff;
  assign o_voltage_interrupt_line = irq_ff;
  assign o_reset_threshold_select = ctl_ff[`CTL_THR_SEL];
  assign o_external_input_select = ext_sel_ff;
endmodule

// file: rtl/por_lvd_consts.svh
// Operation
// [R1] Reset pin below release level holds prescaler and chip in reset.
// [R2] After pin release, prescaler counts 131,072 clocks, then internal reset drops.
// [R3] Reset pin glitches shorter than about 100 ns are filtered out.
// [R4] After power-on reset both detection functions start disabled.
// [R5] Software sets detect enable, waits 150 us, then sets reset enable.
// [R6] Software clears reset enable before detect enable, in separate writes.
// [R7] Supply below reset threshold drives low-voltage reset low, resets prescaler.
// [R8] Supply back above reset threshold restarts prescaler for 131,072 clocks.
// [R9] Low-voltage reset keeps detect enable, threshold select, reset enable.
// [R10] Supply below power-on level causes a full power-on reset.
// [R11] Software sets detect enable, waits 150 us, then sets interrupt enables.
// [R12] Software clears interrupt enables before detect enable, in separate writes.
// [R13] Drop below drop threshold: level low, drop flag set, interrupt if enabled.
// [R14] After drop interrupt software saves data and enters standby.
// [R15] Rise after drop without reset dip: level high, rise flag and interrupt if enabled; the code sets the rise flag only while the rise interrupt is enabled.
// [R16] Reset dip while interrupts active gives low-voltage reset behaviour.
// [R17] External drop comparator below threshold raises a drop interrupt.
// [R18] After external drop, external rise comparator above threshold raises rise interrupt.
// [R19] Software should enable low-voltage reset whenever interrupts are used.
// [R20] 8-bit stabilization counter on clock/4, overflow flag on wrap from all ones.
// [R21] Status flags clear only by writing 0 after reading them as 1.
// [R22] Comparator and pin inputs pass two synchronizing flip-flops.
// [R23] Flags set on transitions, once per crossing.
`ifndef POR_LVD_CONSTS_SVH
`define POR_LVD_CONSTS_SVH
`define OFS_CONTROL 4'h0
`define OFS_STATUS 4'h4
`define OFS_COUNTER 4'h8
`define CTL_DETECT_EN 7
`define CTL_THR_SEL 6
`define CTL_LVR_EN 5
`define CTL_DROP_IE 1
`define CTL_RISE_IE 0
`define CTL_WMASK 8'hE3
`define CTL_RESET 8'h00
`define STS_OVF 7
`define STS_EXT_SEL 3
`define STS_DROP 1
`define STS_RISE 0
`define STS_RSVD_RESET 3'h0
`define CNT_RESET 8'h00
`define CNT_LAST 8'hFF
`define STAB_DIV 4
`define STAB_WAIT_US 150
`define CLK_PERIOD_NS 5
`define FILTER_NS 100
`define FILTER_CYCLES ((`FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELEASE_CYCLES 131072
`endif

// file: rtl/por_lvd_pkg.sv
`include "por_lvd_consts.svh"
package por_lvd_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [31:0] word_t;
  typedef logic [3:0] addr_t;
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_CONTROL = 2'b01,
    SEL_STATUS = 2'b11,
    SEL_COUNTER = 2'b10
  } reg_sel_e;

  function automatic reg_sel_e decode_reg(input addr_t addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (addr == `OFS_CONTROL) begin
      sel = SEL_CONTROL;
    end else if (addr == `OFS_STATUS) begin
      sel = SEL_STATUS;
    end else if (addr == `OFS_COUNTER) begin
      sel = SEL_COUNTER;
    end
    return sel;
  endfunction
endpackage

// file: testbench/por_lvd_asserts.sv
`timescale 1ns/100ps
module por_lvd_asserts #(
  parameter int RELEASE_CYCLES = 131072,
  parameter int FILTER_CYCLES = 20
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_external_reset_pin_n,
  input wire logic i_reset_threshold_below,
  input wire logic i_drop_threshold_below,
  input wire logic i_rise_threshold_above,
  input wire logic i_external_drop_level_input,
  input wire logic i_external_rise_level_input,
  input wire logic o_internal_reset,
  input wire logic o_low_voltage_reset_n,
  input wire logic o_voltage_level_n,
  input wire logic o_voltage_interrupt_line
);
  int pin_high_ff;
  default clocking dclk @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // Cycles the reset pin has stayed high
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_high_ff <= 0;
    end else if (!i_external_reset_pin_n) begin
      pin_high_ff <= 0;
    end else if (pin_high_ff < RELEASE_CYCLES + FILTER_CYCLES) begin
      pin_high_ff <= pin_high_ff + 1;
    end
  end
  property p_wait_once;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("access not answered");
  property p_wait_pulse;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  property p_pin_hold;
    !i_external_reset_pin_n [*8] |-> o_internal_reset;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("reset pin low not holding reset");
  property p_release;
    $fell(o_internal_reset) |-> pin_high_ff >= RELEASE_CYCLES + FILTER_CYCLES;
  endproperty
  a_release: assert property (p_release) else $error("internal reset released early");
  property p_lvr_cause;
    $fell(o_low_voltage_reset_n) |-> $past(i_reset_threshold_below, 2);
  endproperty
  a_lvr_cause: assert property (p_lvr_cause) else $error("low voltage reset without cause");
  property p_lvr_hold;
    !o_low_voltage_reset_n |-> ##[0:2] o_internal_reset;
  endproperty
  a_lvr_hold: assert property (p_lvr_hold) else $error("prescaler not held");
  property p_restart;
    $rose(o_low_voltage_reset_n) |-> o_internal_reset [*8];
  endproperty
  a_restart: assert property (p_restart) else $error("no restart count");
  property p_drop;
    $fell(o_voltage_level_n) |-> $past(i_drop_threshold_below, 2) || !$past(i_external_drop_level_input, 2);
  endproperty
  a_drop: assert property (p_drop) else $error("level fell without drop");
  property p_rise;
    $rose(o_voltage_level_n) |-> $past(i_rise_threshold_above, 2) || $past(i_external_rise_level_input, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("level rose without rise");
  property p_irq_quiet;
    o_internal_reset [*3] |-> !o_voltage_interrupt_line;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt during reset");
  c_lvr: cover property ($fell(o_low_voltage_reset_n));
  c_drop: cover property ($fell(o_voltage_level_n));
  c_irq: cover property ($rose(o_voltage_interrupt_line));
endmodule

// file: testbench/supply_monitor_model.sv
`timescale 1ns/100ps
module supply_monitor_model #(
  parameter int POR_MV = 100,
  parameter int RESET_MV = 2300,
  parameter int DROP_MV = 3700,
  parameter int RISE_MV = 4000,
  parameter int EXT_MV = 1200,
  parameter int CHARGE = 6
) (
  input wire logic i_sys_clk,
  input wire logic i_short,
  input int i_vcc_mv,
  input int i_ext_mv,
  output logic o_pin_n,
  output logic o_por_below,
  output logic o_reset_below,
  output logic o_drop_below,
  output logic o_rise_above,
  output logic o_ext_drop,
  output logic o_ext_rise
);
  int charge = 0;
  // Capacitor charges slowly, discharged once supply collapses
  always @(posedge i_sys_clk) begin
    charge <= (i_vcc_mv < POR_MV) ? 0 : ((charge < CHARGE) ? charge + 1 : charge);
  end
  assign o_pin_n = (charge == CHARGE) && !i_short;
  assign o_por_below = i_vcc_mv < POR_MV;
  assign o_reset_below = i_vcc_mv < RESET_MV;
  assign o_drop_below = i_vcc_mv < DROP_MV;
  assign o_rise_above = i_vcc_mv > RISE_MV;
  assign o_ext_drop = i_ext_mv > EXT_MV;
  assign o_ext_rise = i_ext_mv > EXT_MV;
endmodule

// file: testbench/power_on_low_voltage_reset_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module power_on_low_voltage_reset_tb_top;
  import por_lvd_pkg::*;
  localparam int RELEASE_CYCLES = 16;
  localparam int FILTER_CYCLES = 4;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  addr_t i_avs_address = 4'h0;
  word_t i_avs_writedata = 32'h0000_0000;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic o_avs_waitrequest, i_external_reset_pin_n, i_power_on_below, i_reset_threshold_below;
  logic i_drop_threshold_below, i_rise_threshold_above, i_external_drop_level_input, i_external_rise_level_input;
  logic o_internal_reset, o_low_voltage_reset_n, o_voltage_level_n, o_voltage_interrupt_line;
  logic o_reset_threshold_select, o_external_input_select, seen;
  word_t o_avs_readdata;
  int vcc_mv = 5000;
  int ext_mv = 2000;
  logic short_pin = 1'b0;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  reg8_t q;
  reg8_t rows [6][3] = '{'{8'h00, 8'hDC, 8'hC0}, '{8'h00, 8'h00, 8'h00}, '{8'h04, 8'hFF, 8'h78},
    '{8'h04, 8'h00, 8'h00}, '{8'h08, 8'hAA, 8'h00}, '{8'h0C, 8'hFF, 8'h00}};
  power_on_low_voltage_reset #(.RELEASE_CYCLES(RELEASE_CYCLES), .FILTER_CYCLES(FILTER_CYCLES)) dut (
    .i_sys_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_waitrequest, .o_avs_readdata, .i_external_reset_pin_n, .i_power_on_below, .i_reset_threshold_below,
    .i_drop_threshold_below, .i_rise_threshold_above, .i_external_drop_level_input, .i_external_rise_level_input,
    .o_internal_reset, .o_low_voltage_reset_n, .o_voltage_level_n, .o_voltage_interrupt_line,
    .o_reset_threshold_select, .o_external_input_select);
  supply_monitor_model supply (.i_sys_clk, .i_short(short_pin), .i_vcc_mv(vcc_mv), .i_ext_mv(ext_mv),
    .o_pin_n(i_external_reset_pin_n), .o_por_below(i_power_on_below), .o_reset_below(i_reset_threshold_below),
    .o_drop_below(i_drop_threshold_below), .o_rise_above(i_rise_threshold_above),
    .o_ext_drop(i_external_drop_level_input), .o_ext_rise(i_external_rise_level_input));
  always #2.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 10000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic bus(input logic wr, input addr_t a, input reg8_t d, output reg8_t rd);
    @(posedge i_sys_clk);
    i_avs_address <= a;
    i_avs_writedata <= {24'h00_0000, d};
    i_avs_read <= !wr;
    i_avs_write <= wr;
    do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata[7:0];
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic wait_release(output int k);
    k = 0;
    while (o_internal_reset !== 1'b0 && k < 500) begin
      @(posedge i_sys_clk);
      k++;
    end
  endtask
  task automatic settle(input int v, input int e);
    vcc_mv <= v;
    ext_mv <= e;
    repeat (8) @(posedge i_sys_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_sys_clk);
    `CHK("wait", 1'b1, o_avs_waitrequest)
    `CHK("irq", 1'b0, o_voltage_interrupt_line)
    `CHK("ireset", 1'b1, o_internal_reset)
    i_rst <= 1'b0;
    wait_release(n);
    `CHK("release", 1'b1, n >= RELEASE_CYCLES && n <= RELEASE_CYCLES + FILTER_CYCLES + 20)
    short_pin <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    short_pin <= 1'b0;
    seen = 1'b0;
    repeat (40) @(posedge i_sys_clk) seen |= o_internal_reset;
    `CHK("glitch", 1'b0, seen)
    bus(1'b0, 4'h0, 8'h00, q);
    `CHK("ctl", 8'h00, q)
    foreach (rows[i]) begin
      bus(1'b1, rows[i][0][3:0], rows[i][1], q);
      bus(1'b0, rows[i][0][3:0], 8'h00, q);
      `CHK("reg", rows[i][2], q)
    end
    i_avs_byteenable <= 4'hE;
    bus(1'b1, 4'h0, 8'h80, q);
    i_avs_byteenable <= 4'hF;
    bus(1'b0, 4'h0, 8'h00, q);
    `CHK("lane", 8'h00, q)
    bus(1'b1, 4'h0, 8'h80, q);
    repeat (40) @(posedge i_sys_clk);
    bus(1'b0, 4'h8, 8'h00, q);
    `CHK("count", 1'b1, q >= 8'h08 && q <= 8'h0D)
    repeat (1024) @(posedge i_sys_clk);
    bus(1'b1, 4'h4, 8'h00, q);
    bus(1'b0, 4'h4, 8'h00, q);
    `CHK("ovf", 8'h80, q)
    bus(1'b1, 4'h4, 8'h00, q);
    bus(1'b0, 4'h4, 8'h00, q);
    `CHK("ovfclr", 8'h00, q)
    bus(1'b1, 4'h0, 8'hE0, q);
    @(posedge i_sys_clk);
    `CHK("sel", 1'b1, o_reset_threshold_select)
    settle(3000, 2000);
    `CHK("level", 1'b0, o_voltage_level_n)
    `CHK("irq", 1'b0, o_voltage_interrupt_line)
    bus(1'b0, 4'h4, 8'h00, q);
    `CHK("drop", 8'h02, q & 8'h03)
    settle(2000, 2000);
    `CHK("lvr", 1'b0, o_low_voltage_reset_n)
    `CHK("hold", 1'b1, o_internal_reset)
    vcc_mv <= 5000;
    wait_release(n);
    `CHK("restart", 1'b1, n >= RELEASE_CYCLES && n <= RELEASE_CYCLES + 10)
    bus(1'b0, 4'h0, 8'h00, q);
    `CHK("keep", 8'hE0, q)
    bus(1'b0, 4'h4, 8'h00, q);
    `CHK("flags", 8'h00, q & 8'h03)
    bus(1'b1, 4'h0, 8'hA3, q);
    settle(3000, 2000);
    `CHK("irq", 1'b1, o_voltage_interrupt_line)
    bus(1'b0, 4'h4, 8'h00, q);
    bus(1'b1, 4'h4, 8'h00, q);
    repeat (2) @(posedge i_sys_clk);
    `CHK("irqclr", 1'b0, o_voltage_interrupt_line)
    settle(5000, 2000);
    `CHK("level", 1'b1, o_voltage_level_n)
    `CHK("irq", 1'b1, o_voltage_interrupt_line)
    bus(1'b0, 4'h4, 8'h00, q);
    `CHK("rise", 8'h01, q & 8'h03)
    bus(1'b1, 4'h4, 8'h08, q);
    @(posedge i_sys_clk);
    `CHK("extsel", 1'b1, o_external_input_select)
    settle(5000, 1000);
    bus(1'b0, 4'h4, 8'h00, q);
    `CHK("extdrop", 8'h02, q & 8'h03)
    settle(5000, 2000);
    bus(1'b0, 4'h4, 8'h00, q);
    `CHK("extrise", 8'h03, q & 8'h03)
    bus(1'b1, 4'h4, 8'h00, q);
    bus(1'b1, 4'h0, 8'h83, q);
    settle(2000, 2000);
    `CHK("voltage_interrupt_function", 2'b01, {o_low_voltage_reset_n, o_internal_reset})
    vcc_mv <= 5000;
    wait_release(n);
    `CHK("lvdirel", 1'b1, n < 500)
    bus(1'b1, 4'h0, 8'h80, q);
    bus(1'b1, 4'h0, 8'h00, q);
    bus(1'b0, 4'h8, 8'h00, q);
    `CHK("cntoff", 8'h00, q)
    settle(50, 2000);
    `CHK("por", 1'b1, o_internal_reset)
    vcc_mv <= 5000;
    wait_release(n);
    `CHK("porrel", 1'b1, n < 500)
    bus(1'b0, 4'h0, 8'h00, q);
    `CHK("porctl", 8'h00, q)
    report_and_stop();
  end
endmodule
bind power_on_low_voltage_reset por_lvd_asserts #(.RELEASE_CYCLES(RELEASE_CYCLES), .FILTER_CYCLES(FILTER_CYCLES))
  chk (.i_sys_clk, .i_rst, .i_avs_read, .i_avs_write, .o_avs_waitrequest, .i_external_reset_pin_n,
  .i_reset_threshold_below, .i_drop_threshold_below, .i_rise_threshold_above, .i_external_drop_level_input,
  .i_external_rise_level_input, .o_internal_reset, .o_low_voltage_reset_n, .o_voltage_level_n,
  .o_voltage_interrupt_line);
